// file: rfxc_pkg.sv
// Purpose: constants and types for the right effects coefficient bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per byte register
// Notes:   register index times four is the byte address
// Contract
// - byte pairs form signed 16-bit coefficients
// - numerator tap two low resets to 0x5d
// - numerator tap three resets 0x6b / 0xe3
// - numerator tap four resets 0x96 / 0x66
// - numerator tap five resets 0x67 / 0x5d
// - denominator tap one resets 0x7d / 0x83
// - denominator tap two high resets 0x84
// - each byte is eight bits, read/write
// - numerator tap two high resets 0x67
`default_nettype none
package rfxc_pkg;
    // register indices; byte address is index times four
    localparam logic [7:0] IDX_NUM2_HIGH = 8'h1f;
    localparam logic [7:0] IDX_NUM2_LOW  = 8'h20;
    localparam logic [7:0] IDX_NUM3_HIGH = 8'h21;
    localparam logic [7:0] IDX_NUM3_LOW  = 8'h22;
    localparam logic [7:0] IDX_NUM4_HIGH = 8'h23;
    localparam logic [7:0] IDX_NUM4_LOW  = 8'h24;
    localparam logic [7:0] IDX_NUM5_HIGH = 8'h25;
    localparam logic [7:0] IDX_NUM5_LOW  = 8'h26;
    localparam logic [7:0] IDX_DEN1_HIGH = 8'h27;
    localparam logic [7:0] IDX_DEN1_LOW  = 8'h28;
    localparam logic [7:0] IDX_DEN2_HIGH = 8'h29;
    localparam logic [7:0] IDX_FIRST     = IDX_NUM2_HIGH;
    localparam logic [7:0] IDX_LAST      = IDX_DEN2_HIGH;
    localparam int         NREG          = 11;
    localparam int         BYTE_W        = 8;
    localparam int         ADDR_LSB      = 2;

    // reset values
    localparam logic [7:0] RST_NUM2_HIGH = 8'h67;
    localparam logic [7:0] RST_NUM2_LOW  = 8'h5d;
    localparam logic [7:0] RST_NUM3_HIGH = 8'h6b;
    localparam logic [7:0] RST_NUM3_LOW  = 8'he3;
    localparam logic [7:0] RST_NUM4_HIGH = 8'h96;
    localparam logic [7:0] RST_NUM4_LOW  = 8'h66;
    localparam logic [7:0] RST_NUM5_HIGH = 8'h67;
    localparam logic [7:0] RST_NUM5_LOW  = 8'h5d;
    localparam logic [7:0] RST_DEN1_HIGH = 8'h7d;
    localparam logic [7:0] RST_DEN1_LOW  = 8'h83;
    localparam logic [7:0] RST_DEN2_HIGH = 8'h84;

    // reset table in slot order (slot = index - IDX_FIRST)
    localparam logic [NREG-1:0][7:0] RST_TABLE = {
        RST_DEN2_HIGH, RST_DEN1_LOW, RST_DEN1_HIGH, RST_NUM5_LOW,
        RST_NUM5_HIGH, RST_NUM4_LOW, RST_NUM4_HIGH, RST_NUM3_LOW,
        RST_NUM3_HIGH, RST_NUM2_LOW, RST_NUM2_HIGH};

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // decoded address
    typedef struct packed {
        logic       hit;
        logic [3:0] slot;
    } rfxc_hit_t;

    // coefficients handed to the effects filter
    typedef struct packed {
        logic signed [15:0] numerator_tap_two;
        logic signed [15:0] numerator_tap_three;
        logic signed [15:0] numerator_tap_four;
        logic signed [15:0] numerator_tap_five;
        logic signed [15:0] denominator_tap_one;
        logic        [7:0]  denominator_tap_two_high;
    } rfxc_coeffs_t;
endpackage
`default_nettype wire

// file: rfxc_byte_reg.sv
// Purpose: one coefficient byte with its own reset value
// Assumes: synchronous active-low reset, write enable from the bus slave
// Notes:   read data come straight out of the storage flops
`timescale 1ns/1ps
`default_nettype none
module rfxc_byte_reg
    import rfxc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] q
);
    // reset wins over a write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RESET_VAL;
        end else if (we) begin
            q <= wdata;
        end
    end
endmodule
`default_nettype wire

// file: rfxc_regs.sv
// Purpose: AXI4-Lite bank of right-channel effects filter coefficients
// Assumes: one write and one read outstanding at most, 200 MHz aclk
// Notes:   unmapped or misaligned addresses answer SLVERR, read zero
`timescale 1ns/1ps
`default_nettype none
module rfxc_regs
    import rfxc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    output var  rfxc_coeffs_t      coeffs
);
    // held write request
    logic [ADDR_W-1:0]        aw_addr_q;
    logic [7:0]               w_byte_q;
    logic                     w_strb_q;
    logic                     commit;
    rfxc_hit_t                dec_w;
    rfxc_hit_t                dec_r;
    logic [7:0]               rd_byte;
    logic [NREG-1:0][7:0]     regs;
    logic [NREG-1:0]          reg_we;

    // word address to slot; protection bits do not restrict this bank
    function automatic rfxc_hit_t decode(input logic [ADDR_W-1:0] a);
        rfxc_hit_t  r;
        logic [7:0] idx;
        idx    = 8'(a >> ADDR_LSB);
        r.hit  = (a[ADDR_LSB-1:0] == '0) && (idx >= IDX_FIRST)
                 && (idx <= IDX_LAST);
        r.slot = 4'(idx - IDX_FIRST);
        return r;
    endfunction

    assign dec_w = decode(aw_addr_q);
    assign dec_r = decode(araddr);

    // both halves held and no answer pending: apply the write once
    assign commit = !awready && !wready && !bvalid;

    // write address channel: closed from capture until response taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            awready   <= 1'b0;
            aw_addr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready   <= 1'b1;
        end
    end

    // write data channel: only the low lane carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready   <= 1'b1;
            w_byte_q <= 8'h00;
            w_strb_q <= 1'b0;
        end else if (wvalid && wready) begin
            wready   <= 1'b0;
            w_byte_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
        end else if (bvalid && bready) begin
            wready   <= 1'b1;
        end
    end

    // write response follows the commit by one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (commit) begin
            bvalid <= 1'b1;
            bresp  <= dec_w.hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // per-byte write enables; a cleared lane-0 strobe leaves data alone
    generate
        for (genvar i = 0; i < NREG; i++) begin : g_byte
            assign reg_we[i] = commit && dec_w.hit && w_strb_q
                               && (dec_w.slot == 4'(i));
            // slot reset values
            rfxc_byte_reg #(
                .RESET_VAL (RST_TABLE[i])
            ) u_byte (
                .aclk    (aclk),
                .aresetn (aresetn),
                .we      (reg_we[i]),
                .wdata   (w_byte_q),
                .q       (regs[i])
            );
        end
    endgenerate

    // read mux; an unmapped slot reads zero
    always_comb begin
        rd_byte = 8'h00;
        if (dec_r.hit) begin
            rd_byte = regs[dec_r.slot];
        end
    end

    // read channel: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_byte};
            rresp   <= dec_r.hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // coefficient pairs, high byte on top, read as two's complement
    assign coeffs.numerator_tap_two   = {regs[0], regs[1]};
    assign coeffs.numerator_tap_three = {regs[2], regs[3]};
    assign coeffs.numerator_tap_four  = {regs[4], regs[5]};
    assign coeffs.numerator_tap_five  = {regs[6], regs[7]};
    assign coeffs.denominator_tap_one = {regs[8], regs[9]};
    // low byte of this tap lives outside this bank
    assign coeffs.denominator_tap_two_high = regs[10];

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_reset_release;
        $past(aresetn) == 1'b0;
    endsequence

    sequence s_write_commit;
        commit && dec_w.hit && w_strb_q;
    endsequence

    sequence s_read_take;
        arvalid && arready;
    endsequence

    chk_reset_num2_low: assert property (
        s_reset_release |-> regs[1] == RST_NUM2_LOW
    ) else $error("numerator tap two low byte reset wrong");

    chk_reset_num3_pair: assert property (
        s_reset_release |-> coeffs.numerator_tap_three ==
            {RST_NUM3_HIGH, RST_NUM3_LOW}
    ) else $error("numerator tap three reset wrong");

    chk_reset_num4_pair: assert property (
        s_reset_release |-> coeffs.numerator_tap_four ==
            {RST_NUM4_HIGH, RST_NUM4_LOW}
    ) else $error("numerator tap four reset wrong");

    chk_reset_num5_pair: assert property (
        s_reset_release |-> coeffs.numerator_tap_five ==
            {RST_NUM5_HIGH, RST_NUM5_LOW}
    ) else $error("numerator tap five reset wrong");

    chk_reset_den1_pair: assert property (
        s_reset_release |-> coeffs.denominator_tap_one ==
            {RST_DEN1_HIGH, RST_DEN1_LOW}
    ) else $error("denominator tap one reset wrong");

    chk_reset_den2_high: assert property (
        s_reset_release |-> coeffs.denominator_tap_two_high == RST_DEN2_HIGH
    ) else $error("denominator tap two high byte reset wrong");

    chk_reset_num2_high: assert property (
        s_reset_release |-> regs[0] == RST_NUM2_HIGH
            && coeffs.numerator_tap_two[15:8] == RST_NUM2_HIGH
    ) else $error("numerator tap two high byte reset wrong");

    chk_coeff_sign_bit: assert property (
        (coeffs.denominator_tap_one < 0) == regs[8][7]
            && (coeffs.numerator_tap_two < 0) == regs[0][7]
    ) else $error("coefficient sign does not follow high byte");

    chk_write_lands_byte: assert property (
        s_write_commit |=> regs[$past(dec_w.slot)] == $past(w_byte_q)
            && bvalid && bresp == RESP_OKAY
    ) else $error("write did not land in its byte");

    chk_read_returns_byte: assert property (
        s_read_take |=> rvalid && rdata == {24'h00_0000, $past(rd_byte)}
    ) else $error("read data not the stored byte");

    chk_read_no_effect: assert property (
        s_read_take and (!commit) |=> $stable(regs)
    ) else $error("read changed a register");

    chk_response_order: assert property (
        (bvalid && bready) |=> awready && wready && !bvalid
    ) else $error("write channels not reopened after response");

    chk_read_holds_data: assert property (
        (rvalid && !rready) |=> rvalid && $stable(rdata) && !arready
    ) else $error("read answer dropped before taken");
endmodule
`default_nettype wire

// file: rfxc_regs_tb.sv
// Purpose: self-checking bench for the right effects coefficient bank
// Assumes: AXI4-Lite master driven here, 200 MHz aclk, sync reset
// Notes:   expected values are spelled out locally, not taken from the dut
`timescale 1ns/1ps
`default_nettype none
module rfxc_regs_tb
    import rfxc_pkg::*;
;
    logic         aclk, aresetn;
    logic [7:0]   awaddr, araddr;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp;
    logic         arvalid, arready, rvalid, rready;
    rfxc_coeffs_t coeffs;
    int           errors = 0;
    int           tests_run = 0;
    // reset bytes in address order, starting at byte address 0x7c
    logic [7:0] rst_exp [11] = '{8'h67, 8'h5d, 8'h6b, 8'he3, 8'h96, 8'h66,
                                 8'h67, 8'h5d, 8'h7d, 8'h83, 8'h84};
    // extremes of the signed range sit on taps four and five
    logic [7:0] wr_val [11] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h80, 8'h00,
                                8'h7f, 8'hff, 8'ha5, 8'h5a, 8'hc3};
    logic [31:0] d;
    logic [1:0]  r;

    rfxc_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .coeffs(coeffs));

    // free-running clock, 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write one byte; address and data offered together, bready held high
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      input logic [3:0] s, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n == 50) begin
            errors++;
            print_verdict();
        end
    endtask

    // read one word; rready raised one cycle late so the answer must wait
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rvalid && rready) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b1;
        end
        if (n == 50) begin
            errors++;
            print_verdict();
        end
    endtask

    // every byte reads its reset value, read twice to show no side effect
    task automatic t_reset_values();
        for (int i = 0; i < 11; i++) begin
            rd(8'h7c + 8'(4 * i), d, r);
            check(d, {24'h0, rst_exp[i]});
            check(32'(r), 32'(RESP_OKAY));
            rd(8'h7c + 8'(4 * i), d, r);
            check(d, {24'h0, rst_exp[i]});
        end
        check(32'(coeffs.numerator_tap_three), 32'h6be3);
        check(32'(coeffs.denominator_tap_one), 32'h7d83);
    endtask

    // write all bytes, read them back, look at the paired coefficients
    task automatic t_write_read();
        for (int i = 0; i < 11; i++) begin
            wr(8'h7c + 8'(4 * i), wr_val[i], 4'hf, r);
            check(32'(r), 32'(RESP_OKAY));
        end
        for (int i = 0; i < 11; i++) begin
            rd(8'h7c + 8'(4 * i), d, r);
            check(d, {24'h0, wr_val[i]});
        end
        // signed fields widen with their sign, so -32768 shows as ffff8000
        check(32'(coeffs.numerator_tap_two), 32'h1234);
        check(32'(coeffs.numerator_tap_four), 32'hffff_8000);
        check(32'(coeffs.numerator_tap_five), 32'h7fff);
        check(32'(coeffs.denominator_tap_two_high), 32'hc3);
    endtask

    // unmapped, misaligned and strobe-less accesses must not store
    task automatic t_refused();
        logic [7:0] bad [3] = '{8'h78, 8'ha8, 8'h81};
        for (int i = 0; i < 3; i++) begin
            wr(bad[i], 8'hee, 4'hf, r);
            check(32'(r), 32'(RESP_SLVERR));
            rd(bad[i], d, r);
            check(d, 32'h0);
            check(32'(r), 32'(RESP_SLVERR));
        end
        wr(8'h80, 8'h01, 4'h0, r);
        check(32'(r), 32'(RESP_OKAY));
        for (int i = 0; i < 11; i++) begin
            rd(8'h7c + 8'(4 * i), d, r);
            check(d, {24'h0, wr_val[i]});
        end
    endtask

    // a second reset in mid-run restores every reset value
    task automatic t_mid_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
    endtask

    // reset for 20 cycles, then run the scenarios
    initial begin
        aresetn = 1'b0;
        awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_write_read();
        t_refused();
        t_mid_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
